// ---- design/loud_pkg.sv ----
package loud_pkg;
  // ----------------------------------------------------------------
  // timing of the gated measurement, in hertz, milliseconds and samples
  // ----------------------------------------------------------------
  localparam int SAMPLE_RATE_HZ = 48000; // nominal input sample rate
  localparam int SUB_BLOCK_MS = 100; // spacing between block starts
  localparam int BLOCK_MS = 400; // length of one gating block
  localparam int BLOCK_SUBS = BLOCK_MS / SUB_BLOCK_MS; // sub-blocks per block
  localparam int SUB_BLOCK_SAMPLES = SAMPLE_RATE_HZ / 1000 * SUB_BLOCK_MS;
  localparam int OVERSAMPLE = 4; // true-peak oversampling factor
  // ----------------------------------------------------------------
  // fixed-point formats
  // ----------------------------------------------------------------
  localparam int COEF_W = 18; // filter coefficient width
  localparam int COEF_FRAC = 14; // coefficient fraction bits
  localparam logic signed [17:0] COEF_UNITY = 18'sh04000; // 1.0 in coefficient format
  localparam int GAIN_W = 8; // channel gain width
  localparam int GAIN_FRAC = 6; // channel gain fraction bits
  localparam logic [7:0] GAIN_UNITY = 8'h40; // gain 1.0
  localparam int LOG_FRAC = 4; // fraction bits of log2 values
  localparam int DB_MUL = 385; // 8*10*log10(2)/16 scaled by 2^8
  localparam int DB_SHIFT = 8;
  localparam int K_OFFSET_Q3 = -6; // weighting offset, 1/8 dB units
  localparam int ABS_GATE_Q3 = -560; // -70 LKFS in 1/8 dB
  localparam int REL_GATE_Q3 = 80; // 10 dB in 1/8 dB
  localparam int BIN_Q3 = 8; // histogram bin width, 1 dB
  localparam int NUM_BINS = 70; // bins from -70 LKFS up to 0
  // ----------------------------------------------------------------
  // four-tap interpolator, quarter and half phases
  // ----------------------------------------------------------------
  localparam int CRQ_A = -9;
  localparam int CRQ_B = 111;
  localparam int CRQ_C = 29;
  localparam int CRQ_D = -3;
  localparam int CRQ_SH = 7;
  localparam int CRH_A = -1;
  localparam int CRH_B = 9;
  localparam int CRH_SH = 4;
  // ----------------------------------------------------------------
  // meter control states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_RUN = 4'h2,
    S_ABS = 4'h4,
    S_REL = 4'h8
  } meter_state_t;
endpackage : loud_pkg

// ---- design/chan_if.sv ----
`timescale 1ns/1ps
// per-channel results from the weighting slice to the meter core
interface chan_if #(parameter int DW = 16) ();
  logic valid; // one-cycle strobe per processed sample
  logic [2*DW-1:0] pow; // squared weighted sample
  logic [DW-1:0] peak; // largest magnitude of the oversampled points
  modport src (output valid, output pow, output peak);
  modport snk (input valid, input pow, input peak);
endinterface : chan_if

// ---- design/chan_weight.sv ----
`timescale 1ns/1ps
module chan_weight import loud_pkg::*; #(
  parameter int DW = 16,
  parameter logic [4:0][COEF_W-1:0] PRE_COEF = {{4{18'sh00000}}, COEF_UNITY},
  parameter logic [4:0][COEF_W-1:0] RLB_COEF = {{4{18'sh00000}}, COEF_UNITY}
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic smp_vld_i,
  input wire logic signed [DW-1:0] smp_i,
  chan_if.src out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [DW-1:0] xa1, xa2; // pre-filter input history
    logic signed [DW-1:0] ya1, ya2; // pre-filter output history
    logic signed [DW-1:0] yb1, yb2; // weighting output history
    logic signed [DW-1:0] r1, r2, r3; // raw history for interpolation
    logic vld;
    logic [2*DW-1:0] pow;
    logic [DW-1:0] peak;
  } cw_state_t;
  cw_state_t q, d;

  if (DW < 8 || DW > 24) begin : g_bad_dw
    $error("chan_weight: DW must be 8 to 24");
  end

  // saturate instead of wrapping: a wrapped filter output would fake a huge power
  function automatic logic signed [DW-1:0] sat(input longint v);
    longint hi;
    hi = (longint'(1) <<< (DW - 1)) - 1;
    if (v > hi) sat = DW'(hi);
    else if (v < -hi - 1) sat = DW'(-hi - 1);
    else sat = DW'(v);
  endfunction : sat

  // direct-form biquad, coefficients b0 b1 b2 a1 a2 at index 0..4
  function automatic logic signed [DW-1:0] biquad(input logic signed [DW-1:0] x, x1, x2, y1, y2,
                                                  input logic [4:0][COEF_W-1:0] c);
    longint acc;
    acc = $signed(c[0]) * x + $signed(c[1]) * x1 + $signed(c[2]) * x2
          - $signed(c[3]) * y1 - $signed(c[4]) * y2;
    biquad = sat(acc >>> COEF_FRAC);
  endfunction : biquad

  // one interpolated point from four raw samples
  function automatic int tap(input int s3, s2, s1, s0, ka, kb, kc, kd, sh);
    tap = (ka * s3 + kb * s2 + kc * s1 + kd * s0) >>> sh;
  endfunction : tap

  // magnitude clipped to the output width
  function automatic logic [DW-1:0] mag(input int v);
    int a;
    a = (v < 0) ? -v : v;
    mag = (a > (1 << DW) - 1) ? {DW{1'b1}} : DW'(a);
  endfunction : mag

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [DW-1:0] ya;
    logic signed [DW-1:0] yb;
    logic signed [2*DW-1:0] sq;
    logic [DW-1:0] m;
    int s0, s1, s2, s3;
    d = q;
    s0 = int'(smp_i);
    s1 = int'(q.r1);
    s2 = int'(q.r2);
    s3 = int'(q.r3);
    // head pre-filter then low-frequency weighting curve
    ya = biquad(smp_i, q.xa1, q.xa2, q.ya1, q.ya2, PRE_COEF); // R2
    yb = biquad(ya, q.ya1, q.ya2, q.yb1, q.yb2, RLB_COEF); // R2
    sq = yb * yb; // R3
    // three points between r2 and r1 plus r1 itself give four per input sample
    m = mag(s1); // R9
    if (mag(tap(s3, s2, s1, s0, CRQ_A, CRQ_B, CRQ_C, CRQ_D, CRQ_SH)) > m) begin // R9
      m = mag(tap(s3, s2, s1, s0, CRQ_A, CRQ_B, CRQ_C, CRQ_D, CRQ_SH));
    end
    if (mag(tap(s3, s2, s1, s0, CRH_A, CRH_B, CRH_B, CRH_A, CRH_SH)) > m) begin // R9
      m = mag(tap(s3, s2, s1, s0, CRH_A, CRH_B, CRH_B, CRH_A, CRH_SH));
    end
    if (mag(tap(s3, s2, s1, s0, CRQ_D, CRQ_C, CRQ_B, CRQ_A, CRQ_SH)) > m) begin // R9
      m = mag(tap(s3, s2, s1, s0, CRQ_D, CRQ_C, CRQ_B, CRQ_A, CRQ_SH));
    end
    d.vld = smp_vld_i;
    // histories move only on a real sample
    if (smp_vld_i) begin
      d.xa1 = smp_i;
      d.xa2 = q.xa1;
      d.ya1 = ya;
      d.ya2 = q.ya1;
      d.yb1 = yb;
      d.yb2 = q.yb1;
      d.r1 = smp_i;
      d.r2 = q.r1;
      d.r3 = q.r2;
      d.pow = sq;
      d.peak = m;
    end
    // synchronous reset
    if (!rst_b_i) begin
      d = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign out.valid = q.vld;
  assign out.pow = q.pow;
  assign out.peak = q.peak;
endmodule : chan_weight

// ---- design/loudness_true_peak_meter.sv ----
`timescale 1ns/1ps
// Function
// R1 - weight each channel's power, then sum
// R2 - pre-filter cascaded with low-frequency weighting
// R3 - loudness from mean of squared samples
// R4 - ungated: average over whole start-stop run
// R5 - 400 ms blocks started every 100 ms
// R6 - drop blocks below -70 LKFS
// R7 - relative gate 10 dB below gated value
// R8 - histogram bins, recompute every 100 ms
// R9 - fourfold oversampling for true peak
// R10 - hold largest oversampled magnitude until restart
// R11 - log conversion before gate comparisons
module loudness_true_peak_meter import loud_pkg::*; #(
  parameter int CH = 5,
  parameter int DW = 16,
  parameter int NB = NUM_BINS,
  parameter int SUB_SAMPLES = SUB_BLOCK_SAMPLES,
  parameter logic [4:0][COEF_W-1:0] PRE_COEF = {{4{18'sh00000}}, COEF_UNITY},
  parameter logic [4:0][COEF_W-1:0] RLB_COEF = {{4{18'sh00000}}, COEF_UNITY}
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic START_I,
  input wire logic STOP_I,
  input wire logic GATED_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic [CH-1:0][DW-1:0] SAMPLE_I,
  input wire logic [CH-1:0][GAIN_W-1:0] CHAN_GAIN_I,
  output logic signed [15:0] LOUDNESS_O,
  output logic LOUDNESS_VALID_O,
  output logic [DW-1:0] TRUE_PEAK_O,
  output logic RUNNING_O
);
  // ----------------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------------
  localparam int AW = 64; // accumulator width
  localparam int NSW = $clog2(BLOCK_SUBS); // sub-block fill counter width
  localparam int FS_LOG_Q4 = 2 * (DW - 1) * (1 << LOG_FRAC); // log2 of full-scale power

  if (CH < 1 || NB < 2 || NB > 255 || SUB_SAMPLES < 1) begin : g_bad_par
    $error("loudness_true_peak_meter: unsupported parameters");
  end

  // log2 with LOG_FRAC fraction bits, taken from the leading one; zero maps to zero
  function automatic int log2q(input logic [AW-1:0] x);
    int p;
    logic [AW-1:0] n;
    p = 0;
    for (int i = 0; i < AW; i++) begin
      if (x[i]) p = i;
    end
    n = x << (AW - 1 - p);
    log2q = p * (1 << LOG_FRAC) + int'(n[AW-2 -: LOG_FRAC]);
  endfunction : log2q

  // log2 of mean power to loudness in 1/8 dB, relative to full scale
  function automatic logic signed [15:0] to_lkfs(input int l);
    int db;
    db = (((l - FS_LOG_Q4) * DB_MUL) >>> DB_SHIFT) + K_OFFSET_Q3; // R11
    to_lkfs = 16'(db);
  endfunction : to_lkfs

  localparam int LOG_N = log2q(AW'(BLOCK_SUBS * SUB_SAMPLES)); // log2 of the samples per block

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    meter_state_t st;
    logic run; // measurement in progress
    logic gated; // mode caught at start
    logic [31:0] sub_cnt; // samples in the open sub-block
    logic [AW-1:0] sub_acc; // power of the open sub-block
    logic [BLOCK_SUBS-2:0][AW-1:0] subs; // last closed sub-blocks
    logic [NSW-1:0] nsub; // closed sub-blocks before the first block
    logic [AW-1:0] int_acc; // power over the whole run
    logic [31:0] int_cnt; // samples over the whole run
    logic [NB-1:0][31:0] bin_cnt; // blocks per loudness bin
    logic [NB-1:0][AW-1:0] bin_sum; // block power per loudness bin
    logic [7:0] idx; // bin scan pointer
    logic [AW-1:0] tot_sum;
    logic [31:0] tot_cnt;
    logic signed [15:0] thr; // relative gate threshold
    logic signed [15:0] loud;
    logic vld;
    logic [DW-1:0] peak;
  } meter_t;
  meter_t q, d;

  logic [CH-1:0][2*DW-1:0] pow_w; // squared weighted sample per channel
  logic [CH-1:0][DW-1:0] pk_w; // oversampled peak per channel
  logic vld_w; // all channels step together

  // ----------------------------------------------------------------
  // channel slices
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CH; g++) begin : g_ch
    chan_if #(.DW(DW)) u_if ();
    chan_weight #(.DW(DW), .PRE_COEF(PRE_COEF), .RLB_COEF(RLB_COEF)) u_cw ( // R2 R3 R9
      .clk_i(CLK_I),
      .rst_b_i(RST_B_I),
      .smp_vld_i(SAMPLE_VALID_I),
      .smp_i(SAMPLE_I[g]),
      .out(u_if)
    );
    assign pow_w[g] = u_if.pow;
    assign pk_w[g] = u_if.peak;
    if (g == 0) begin : g_vld
      assign vld_w = u_if.valid;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [AW-1:0] pw;
    logic [AW-1:0] blk;
    logic [AW-1:0] ts;
    logic [31:0] tc;
    logic [DW-1:0] pk;
    int bq, bi, lq;
    d = q;
    d.vld = 1'b0;
    pw = '0;
    pk = '0;
    blk = '0;
    ts = '0;
    tc = '0;
    bq = 0;
    bi = 0;
    lq = 0;
    // gain-weighted channel sum and largest channel peak
    for (int c = 0; c < CH; c++) begin
      pw = pw + ((AW'(pow_w[c]) * AW'(CHAN_GAIN_I[c])) >> GAIN_FRAC); // R1
      if (pk_w[c] > pk) pk = pk_w[c];
    end
    // bin scans: first the absolutely gated level, then the relative pass
    unique case (q.st)
      S_IDLE, S_RUN: begin
      end
      S_ABS: begin
        ts = q.tot_sum + q.bin_sum[q.idx]; // R8
        tc = q.tot_cnt + q.bin_cnt[q.idx];
        d.tot_sum = ts;
        d.tot_cnt = tc;
        d.idx = q.idx + 8'h01;
        if (q.idx == 8'(NB - 1)) begin
          lq = int'(to_lkfs(log2q(ts) - log2q(AW'(tc)) - LOG_N));
          d.thr = 16'(lq - REL_GATE_Q3); // R7
          d.idx = '0;
          d.tot_sum = '0;
          d.tot_cnt = '0;
          // no block passed the absolute gate: keep the last result
          d.st = (tc == '0) ? (q.run ? S_RUN : S_IDLE) : S_REL;
        end
      end
      S_REL: begin
        // a bin is ignored when its top edge lies at or under the threshold
        if (ABS_GATE_Q3 + BIN_Q3 * (int'(q.idx) + 1) > int'(q.thr)) begin // R7 R8
          d.tot_sum = q.tot_sum + q.bin_sum[q.idx];
          d.tot_cnt = q.tot_cnt + q.bin_cnt[q.idx];
        end
        d.idx = q.idx + 8'h01;
        if (q.idx == 8'(NB - 1)) begin
          if (d.tot_cnt != '0) begin
            d.loud = to_lkfs(log2q(d.tot_sum) - log2q(AW'(d.tot_cnt)) - LOG_N); // R7
            d.vld = 1'b1;
          end
          d.st = q.run ? S_RUN : S_IDLE;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
    if (START_I) begin
      // restart clears every accumulator, the bins and the held peak
      d = '0; // R10
      d.st = S_RUN;
      d.run = 1'b1;
      d.gated = GATED_I;
    end else if (STOP_I && q.run) begin
      d.run = 1'b0;
      if (q.gated) begin
        d.st = S_ABS;
        d.idx = '0;
        d.tot_sum = '0;
        d.tot_cnt = '0;
      end else begin
        d.st = S_IDLE;
        d.loud = to_lkfs(log2q(q.int_acc) - log2q(AW'(q.int_cnt))); // R4
        d.vld = 1'b1;
      end
    end else if (q.run && vld_w) begin
      // mean-square accumulation, whole run and current sub-block
      d.int_acc = q.int_acc + pw; // R3 R4
      d.int_cnt = q.int_cnt + 32'h1;
      d.sub_acc = q.sub_acc + pw; // R3
      d.sub_cnt = q.sub_cnt + 32'h1;
      if (pk > q.peak) d.peak = pk; // R10
      if (q.sub_cnt == 32'(SUB_SAMPLES - 1)) begin
        // sub-block closes: the block is it plus the previous closed ones
        blk = q.sub_acc + pw; // R5
        for (int k = 0; k < BLOCK_SUBS - 1; k++) begin
          blk = blk + q.subs[k]; // R5
        end
        for (int k = BLOCK_SUBS - 2; k > 0; k--) begin
          d.subs[k] = q.subs[k-1];
        end
        d.subs[0] = q.sub_acc + pw;
        d.sub_acc = '0;
        d.sub_cnt = '0;
        if (q.nsub == NSW'(BLOCK_SUBS - 1)) begin
          bq = int'(to_lkfs(log2q(blk) - LOG_N)); // R11
          if (bq >= ABS_GATE_Q3) begin // R6
            bi = (bq - ABS_GATE_Q3) / BIN_Q3; // R8
            if (bi > NB - 1) bi = NB - 1;
            d.bin_cnt[bi] = q.bin_cnt[bi] + 32'h1; // R8
            d.bin_sum[bi] = q.bin_sum[bi] + blk;
          end
        end else begin
          d.nsub = q.nsub + NSW'(1);
        end
        if (q.gated) begin
          // recompute the gated result once per sub-block
          d.st = S_ABS; // R8
          d.idx = '0;
          d.tot_sum = '0;
          d.tot_cnt = '0;
        end else begin
          d.loud = to_lkfs(log2q(d.int_acc) - log2q(AW'(d.int_cnt))); // R4
          d.vld = 1'b1;
        end
      end
    end
    // synchronous reset
    if (!RST_B_I) begin
      d = '0;
      d.st = S_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    q <= d;
  end

  assign LOUDNESS_O = q.loud;
  assign LOUDNESS_VALID_O = q.vld;
  assign TRUE_PEAK_O = q.peak;
  assign RUNNING_O = q.run;
endmodule : loudness_true_peak_meter

// ---- dv/loud_meter_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks of the meter
// ----------------------------------------------------------------
module loud_meter_checker import loud_pkg::*; #(
  parameter int NB = NUM_BINS,
  parameter int DW = 16
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic START_I,
  input wire logic STOP_I,
  input wire logic GATED_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic signed [15:0] LOUDNESS_O,
  input wire logic LOUDNESS_VALID_O,
  input wire logic [DW-1:0] TRUE_PEAK_O,
  input wire logic RUNNING_O
);
  logic gated_q; // mode latched on start, as the meter does
  logic [15:0] since_q; // edges since the last start or result
  // helpers; since_q saturates so a long idle never wraps back into range
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      gated_q <= 1'b0;
      since_q <= 16'hFFFF;
    end else begin
      if (START_I) gated_q <= GATED_I;
      if (START_I || LOUDNESS_VALID_O) since_q <= 16'h0000;
      else if (since_q != 16'hFFFF) since_q <= since_q + 16'h0001;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // an ungated run being stopped, then its closing result
  sequence s_stop_ungated;
    STOP_I && RUNNING_O && !START_I && !gated_q;
  endsequence
  sequence s_final_pulse;
    !RUNNING_O && LOUDNESS_VALID_O;
  endsequence
  start_runs_a: assert property (START_I |=> RUNNING_O)
    else $error("run flag not raised by start");
  start_clears_a: assert property (START_I && !$past(SAMPLE_VALID_I) |=> TRUE_PEAK_O == '0)
    else $error("start left the peak set");
  stop_ends_a: assert property (s_stop_ungated |=> s_final_pulse)
    else $error("ungated stop gave no closing result");
  peak_hold_a: assert property (!START_I |=> TRUE_PEAK_O >= $past(TRUE_PEAK_O))
    else $error("held peak fell");
  peak_cause_a: assert property ($changed(TRUE_PEAK_O) |->
    $past(SAMPLE_VALID_I, 2) || $past(START_I)) else $error("peak moved without a sample");
  ungated_cause_a: assert property (LOUDNESS_VALID_O && !gated_q |-> $past(STOP_I) ||
    $past(STOP_I, 2) || $past(SAMPLE_VALID_I, 2) || $past(SAMPLE_VALID_I, 3))
    else $error("ungated result without cause");
  result_stable_a: assert property (!LOUDNESS_VALID_O && !$past(START_I) |->
    $stable(LOUDNESS_O)) else $error("result moved without a pulse");
  gated_late_a: assert property (gated_q && LOUDNESS_VALID_O |-> since_q >= 16'(2 * NB))
    else $error("gated result before both scan passes");
  gated_floor_a: assert property (gated_q && LOUDNESS_VALID_O |-> LOUDNESS_O >= ABS_GATE_Q3)
    else $error("gated result below the absolute gate");
endmodule : loud_meter_checker

bind loudness_true_peak_meter loud_meter_checker #(.NB(NB), .DW(DW)) i_loud_meter_checker (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .START_I(START_I), .STOP_I(STOP_I), .GATED_I(GATED_I),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .LOUDNESS_O(LOUDNESS_O), .LOUDNESS_VALID_O(LOUDNESS_VALID_O),
  .TRUE_PEAK_O(TRUE_PEAK_O), .RUNNING_O(RUNNING_O));

// ---- dv/pcm_source_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sample source and result sink beyond the meter
// ----------------------------------------------------------------
module pcm_source_model #(
  parameter int CH = 5,
  parameter int DW = 16,
  parameter int GAP = 150
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic go_i, // load a burst
  input wire logic flip_i, // sign pattern + + - - for intersample peaks
  input wire logic [15:0] count_i, // samples in the burst
  input wire logic [CH-1:0][DW-1:0] level_i, // per-channel level
  output logic smp_vld_o,
  output logic [CH-1:0][DW-1:0] smp_o,
  output logic busy_o,
  input wire logic res_vld_i,
  input wire logic [15:0] res_i,
  output logic [15:0] last_res_o,
  output logic [15:0] n_res_o
);
  logic [15:0] left = 16'h0000; // samples still to send
  int gap = 0; // cycles to the next strobe
  logic [1:0] phase = 2'b00; // place in the sign pattern
  initial {smp_vld_o, busy_o, smp_o, n_res_o, last_res_o} = '0;
  // strobes GAP apart; the bus toggles in between, so a meter reading
  // it off the strobe sees junk rather than a kindly held value
  always @(posedge clk_i) begin
    smp_vld_o <= 1'b0;
    smp_o <= ~smp_o;
    if (!rst_b_i) begin
      left <= 16'h0000;
      busy_o <= 1'b0;
    end else if (go_i) begin
      left <= count_i;
      gap <= 0;
      busy_o <= 1'b1;
    end else if (left != 16'h0000) begin
      if (gap == 0) begin
        for (int c = 0; c < CH; c++) begin
          smp_o[c] <= (flip_i && phase[1]) ? -level_i[c] : level_i[c];
        end
        smp_vld_o <= 1'b1;
        phase <= phase + 2'b01;
        left <= left - 16'h0001;
        gap <= GAP - 1;
      end else begin
        gap <= gap - 1;
      end
    end else begin
      busy_o <= 1'b0;
    end
  end
  // sink: keep the latest result and count the pulses
  always @(posedge clk_i) begin
    if (res_vld_i === 1'b1) begin
      last_res_o <= res_i;
      n_res_o <= n_res_o + 16'h0001;
    end
  end
endmodule : pcm_source_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import loud_pkg::*;
  // ----------------------------------------------------------------
  // short sub-blocks keep the run brief; GAP leaves room for a scan
  // ----------------------------------------------------------------
  localparam int CH = 5;
  localparam int DW = 16;
  localparam int NB = NUM_BINS;
  localparam int SUBS = 8;
  localparam int GAP = 2 * NB + 10;
  localparam logic [DW-1:0] FULL = 16'h4000; // power 2^28
  localparam logic [DW-1:0] QUIET = 16'h0400; // 24 dB under FULL
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic gated = 1'b0;
  logic go = 1'b0;
  logic flip = 1'b0;
  logic [15:0] count = 16'h0000;
  logic [CH-1:0][DW-1:0] level = '0;
  logic [CH-1:0][GAIN_W-1:0] gain = {CH{GAIN_UNITY}};
  logic smp_vld;
  logic [CH-1:0][DW-1:0] smp;
  logic busy;
  logic signed [15:0] res;
  logic res_vld;
  logic [DW-1:0] peak;
  logic running;
  logic signed [15:0] last_res;
  logic [15:0] n_res;
  int n_fail = 0;
  int n_tests = 0;
  initial forever #25 clk = ~clk;
  loudness_true_peak_meter #(.CH(CH), .DW(DW), .NB(NB), .SUB_SAMPLES(SUBS))
    i_loudness_true_peak_meter (.CLK_I(clk), .RST_B_I(rst_b), .START_I(start), .STOP_I(stop),
    .GATED_I(gated), .SAMPLE_VALID_I(smp_vld), .SAMPLE_I(smp), .CHAN_GAIN_I(gain),
    .LOUDNESS_O(res), .LOUDNESS_VALID_O(res_vld), .TRUE_PEAK_O(peak), .RUNNING_O(running));
  pcm_source_model #(.CH(CH), .DW(DW), .GAP(GAP)) i_pcm_source_model (.clk_i(clk),
    .rst_b_i(rst_b), .go_i(go), .flip_i(flip), .count_i(count), .level_i(level),
    .smp_vld_o(smp_vld), .smp_o(smp), .busy_o(busy), .res_vld_i(res_vld), .res_i(res),
    .last_res_o(last_res), .n_res_o(n_res));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t ns %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  function automatic logic near(input logic signed [15:0] v, input int e);
    return (v >= e - 8) && (v <= e + 8); // bins and log step allow one dB
  endfunction : near
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  // hand a burst to the source and wait, bounded, until it is sent
  task automatic send(input int n, input logic [DW-1:0] a0, input logic [DW-1:0] a1,
                      input logic [7:0] g0, input logic f);
    int i;
    @(posedge clk);
    level <= {{(CH-2){16'h0000}}, a1, a0};
    gain <= {{(CH-1){GAIN_UNITY}}, g0};
    flip <= f;
    count <= 16'(n);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < n * GAP + 20; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    if (busy !== 1'b0) begin
      n_fail++;
      $display("ERROR %0t ns source hung", $time);
      print_verdict();
    end
  endtask : send
  // one-cycle start or stop, mode taken along with a start
  task automatic ctl(input logic is_start, input logic mode);
    @(posedge clk);
    if (is_start) start <= 1'b1;
    else stop <= 1'b1;
    gated <= mode;
    @(posedge clk);
    start <= 1'b0;
    stop <= 1'b0;
    @(negedge clk);
  endtask : ctl
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // ungated run: progress result at the sub-block end, closing result at stop
  task automatic t_ungated(input logic [DW-1:0] a0, input logic [DW-1:0] a1,
                           input logic [7:0] g0, input logic f, input int e,
                           input logic [DW-1:0] pk);
    logic [15:0] n0;
    send(4, a0, a1, g0, f); // filter history only, not measured
    ctl(1'b1, 1'b0);
    n0 = n_res;
    check(32'(running), 1, "run after start");
    send(SUBS, a0, a1, g0, f);
    settle(4);
    check(32'(n_res - n0), 1, "progress count");
    check(last_res, e, "progress level");
    ctl(1'b0, 1'b0);
    settle(2);
    check(32'(running), 0, "run after stop");
    check(32'(n_res - n0), 2, "stop count");
    check(last_res, e, "closing level");
    check(32'(peak), 32'(pk), "peak");
  endtask : t_ungated
  // gated steady tone: nothing until four sub-blocks, then each 100 ms
  task automatic t_gated_steady;
    logic [15:0] n0;
    ctl(1'b1, 1'b1);
    n0 = n_res;
    send(3 * SUBS, FULL, 16'h0000, GAIN_UNITY, 1'b0);
    settle(2 * NB + 10);
    check(32'(n_res - n0), 0, "early block");
    send(SUBS, FULL, 16'h0000, GAIN_UNITY, 1'b0);
    settle(2 * NB + 10);
    check(32'(n_res - n0), 1, "first block");
    check(32'(near(last_res, -55)), 1, "block level");
    send(SUBS, FULL, 16'h0000, GAIN_UNITY, 1'b0);
    settle(2 * NB + 10);
    check(32'(n_res - n0), 2, "second block");
    ctl(1'b0, 1'b0);
    settle(2 * NB + 10);
    check(32'(n_res - n0), 3, "final scan");
  endtask : t_gated_steady
  // silence never passes the absolute gate
  task automatic t_gated_silent;
    logic [15:0] n0;
    send(4, 16'h0000, 16'h0000, GAIN_UNITY, 1'b0); // clear interpolator history
    ctl(1'b1, 1'b1);
    n0 = n_res;
    send(5 * SUBS, 16'h0000, 16'h0000, GAIN_UNITY, 1'b0);
    ctl(1'b0, 1'b0);
    settle(2 * NB + 10);
    check(32'(n_res - n0), 0, "silent result");
    check(32'(peak), 0, "silent peak");
  endtask : t_gated_silent
  // loud then quiet: relative gate keeps the result near the loud part
  task automatic t_relative;
    ctl(1'b1, 1'b1);
    send(4 * SUBS, FULL, 16'h0000, GAIN_UNITY, 1'b0);
    send(4 * SUBS, QUIET, 16'h0000, GAIN_UNITY, 1'b0);
    ctl(1'b0, 1'b0);
    settle(2 * NB + 10);
    check(32'(last_res > -76), 1, "relative gate");
  endtask : t_relative
  // restart in mid-run clears the held peak
  task automatic t_restart;
    send(4, FULL, 16'h0000, GAIN_UNITY, 1'b0); // a step would overshoot the peak
    ctl(1'b1, 1'b0);
    send(4, FULL, 16'h0000, GAIN_UNITY, 1'b0);
    check(32'(peak), 32'(FULL), "peak before restart");
    ctl(1'b1, 1'b0);
    check({running, 15'h0000, peak}, 32'h80000000, "restart");
    ctl(1'b0, 1'b0);
  endtask : t_restart
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (19) @(posedge clk);
    @(negedge clk);
    check({res, peak}, 0, "result and peak in reset");
    check({res_vld, running}, 0, "flags in reset");
    @(posedge clk);
    rst_b <= 1'b1;
    t_ungated(FULL, 16'h0000, GAIN_UNITY, 1'b0, -55, FULL);
    t_ungated(FULL, 16'h0000, 8'h20, 1'b0, -79, FULL);
    t_ungated(FULL, FULL, GAIN_UNITY, 1'b0, -31, FULL);
    t_ungated(16'hC000, 16'h0000, GAIN_UNITY, 1'b0, -55, FULL);
    t_ungated(16'h1000, 16'h0000, GAIN_UNITY, 1'b1, -151, 16'h1400);
    t_gated_steady();
    t_gated_silent();
    t_relative();
    t_restart();
    print_verdict();
  end
endmodule : tb_top
